// [bench/cpl_stage.sv]
/*
 power stage sensor model for the channel protection logic.
 assumes the bench sets the fault commands and reads ch_on back.
*/
module cpl_stage
(
	input wire logic [5:0] ch_on,
	input wire logic [5:0] red_thr_sel,
	input wire logic [5:0] short_cmd,
	input wire logic [5:0] hot_cmd,
	input wire logic [5:0] spike_cmd,
	output logic [5:0] vds_high,
	output logic [5:0] oc_vtrip,
	output logic [5:0] oc_itrip,
	output logic [5:0] over_temp,
	output logic [5:0] temp_cooled,
	output logic [5:0] dyn_temp
);
	timeunit 1ns;
	timeprecision 1ns;
	// a short only draws current while the channel drives it
	assign vds_high = short_cmd & ch_on;
	assign oc_vtrip = short_cmd & ch_on & ~red_thr_sel;
	assign oc_itrip = short_cmd & ch_on & red_thr_sel;
	// cooled flag is the plain inverse, no hysteresis timing
	assign over_temp = hot_cmd;
	assign temp_cooled = ~hot_cmd;
	assign dyn_temp = spike_cmd;
endmodule

// [bench/tb.sv]
/*
 self-checking bench for the channel protection logic, channel 0.
 assumes short trip delay and retry limit set at the instance.
*/
`include "cpl_cfg.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst_b = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [5:0] in_pin = 6'h00, ch_on, red, vds, vtr, itr, ot, cool, dyn;
	logic [5:0] shrt = 6'h00, hot = 6'h00, spk = 6'h00;
	logic [31:0] d;
	int bad_count = 0, compares = 0;
	always #25 core_clk = ~core_clk;
	cpl_core #(.TRIP_CYC(20), .RETRY_LIMIT(2)) DUT (.core_clk(core_clk),
		.rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .in_pin(in_pin), .vds_high(vds),
		.oc_vtrip(vtr), .oc_itrip(itr), .over_temp(ot),
		.temp_cooled(cool), .dyn_temp(dyn), .ch_on(ch_on),
		.red_thr_sel(red));
	cpl_stage stage (.ch_on(ch_on), .red_thr_sel(red), .short_cmd(shrt),
		.hot_cmd(hot), .spike_cmd(spk), .vds_high(vds), .oc_vtrip(vtr),
		.oc_itrip(itr), .over_temp(ot), .temp_cooled(cool),
		.dyn_temp(dyn));
	task automatic complete_run();
		$display("checks %0d errors %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// master holds each channel until its own handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (int i = 0; i < 50; i++)
		begin
			@(posedge core_clk);
			if (awvalid && awready)
				awvalid <= 0;
			if (wvalid && wready)
				wvalid <= 0;
			if (bvalid === 1'b1)
			begin
				rsp = bresp;
				bready <= 0;
				// idle edge: a next call must not drive bready in this step
				@(posedge core_clk);
				return;
			end
		end
		bad_count++;
		complete_run();
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (int i = 0; i < 50; i++)
		begin
			@(posedge core_clk);
			if (arvalid && arready)
				arvalid <= 0;
			if (rvalid === 1'b1)
			begin
				d = rdata;
				rsp = rresp;
				rready <= 0;
				@(posedge core_clk);
				return;
			end
		end
		bad_count++;
		complete_run();
	endtask
	// sync pipeline delays every effect by a few edges
	task automatic wch(input logic v);
		for (int i = 0; i < 20 && ch_on[0] !== v; i++)
			@(posedge core_clk);
		chk("ch_on0", v, ch_on[0]);
		if (ch_on[0] !== v)
			complete_run();
	endtask
	task automatic lat(input logic [31:0] e);
		rd(`CPL_LAT_OFS);
		chk("lat", e, d);
	endtask
	task automatic err(input logic [31:0] e);
		rd(`CPL_ERR_OFS);
		chk("err", e, d);
	endtask
	task automatic s_regs();
		rd(`CPL_OUT_OFS);
		chk("out", 32'h0, d);
		wr(`CPL_CFG_OFS, 32'h8);
		chk("wr_okay", 32'h0, {30'h0, rsp});
		rd(`CPL_CFG_OFS);
		chk("cfg", 32'h8, d);
		chk("rd_okay", 32'h0, {30'h0, rsp});
		wr(`CPL_CFG_OFS, 32'h0);
		rd(8'h20);
		chk("unmapped", 32'h2, {30'h0, rsp});
		wr(`CPL_ERR_OFS, 32'h1);
		chk("ro_write", 32'h2, {30'h0, rsp});
	endtask
	task automatic s_comb();
		wr(`CPL_OUT_OFS, 32'h1);
		wch(1);
		wr(`CPL_OUT_OFS, 32'h0);
		wch(0);
		in_pin <= 6'h01;
		wch(1);
		wr(`CPL_CFG_OFS, 32'h8);
		wch(0);
		wr(`CPL_OUT_OFS, 32'h1);
		wch(1);
		wr(`CPL_CFG_OFS, 32'h0);
		in_pin <= 6'h00;
	endtask
	task automatic s_vtrip();
		shrt <= 6'h01;
		wch(0);
		lat(32'h1);
		err(32'h1);
		err(32'h1);
		shrt <= 6'h00;
		wr(`CPL_HARDWARE_CONFIG_REG_OFS, 32'h1);
		wch(1);
		lat(32'h0);
		rd(`CPL_ERR_OFS);
		err(32'h0);
	endtask
	task automatic s_itrip();
		chk("red0", 32'h0, {31'h0, red[0]});
		tick(30);
		chk("red0", 32'h1, {31'h0, red[0]});
		rd(`CPL_STAT_OFS);
		chk("stat", 32'h101, d);
		in_pin <= 6'h01;
		tick(8);
		chk("red0", 32'h0, {31'h0, red[0]});
		tick(30);
		shrt <= 6'h01;
		wch(0);
		lat(32'h1);
		shrt <= 6'h00;
		in_pin <= 6'h00;
		wr(`CPL_HARDWARE_CONFIG_REG_OFS, 32'h1);
		wch(1);
		rd(`CPL_ERR_OFS);
	endtask
	task automatic s_ot();
		hot <= 6'h01;
		wch(0);
		lat(32'h100);
		wr(`CPL_HARDWARE_CONFIG_REG_OFS, 32'h1);
		tick(8);
		wch(0);
		hot <= 6'h00;
		tick(8);
		wch(0);
		wr(`CPL_HARDWARE_CONFIG_REG_OFS, 32'h1);
		wch(1);
		lat(32'h0);
	endtask
	task automatic spike();
		spk <= 6'h01;
		wch(0);
		spk <= 6'h00;
		tick(8);
	endtask
	task automatic s_dyn();
		spk <= 6'h01;
		wch(0);
		err(32'h1);
		err(32'h1);
		spk <= 6'h00;
		wch(1);
		rd(`CPL_ERR_OFS);
		err(32'h0);
		wr(`CPL_OUT_OFS, 32'h0);
		wch(0);
		wr(`CPL_OUT_OFS, 32'h1);
		wch(1);
		spike();
		spike();
		wch(1);
		lat(32'h0);
		spike();
		wch(0);
		lat(32'h10000);
		wr(`CPL_HARDWARE_CONFIG_REG_OFS, 32'h1);
		wch(1);
	endtask
	initial
	begin
		tick(3);
		rst_b <= 1;
		tick(1);
		s_regs();
		s_comb();
		s_vtrip();
		s_itrip();
		s_ot();
		s_dyn();
		complete_run();
	end
endmodule

// [rtl/cpl_cfg.svh]
/*
 constants for the channel protection latch logic: offsets, bits, timing.
 assumes a 20 MHz core clock and 32-bit register words.
*/
`ifndef CPL_CFG_SVH
`define CPL_CFG_SVH
`define CPL_NCH 6
`define CPL_CLK_HZ 20000000
// trip delay in microseconds, converted to core clock cycles
`define CPL_TRIP_US 7000
`define CPL_TRIP_CYC (`CPL_TRIP_US * (`CPL_CLK_HZ / 1000000))
`define CPL_RETRY_LIMIT 4
`define CPL_OUT_OFS 8'h00
`define CPL_HARDWARE_CONFIG_REG_OFS 8'h04
`define CPL_CFG_OFS 8'h08
`define CPL_ERR_OFS 8'h0C
`define CPL_LAT_OFS 8'h10
`define CPL_STAT_OFS 8'h14
`define CPL_CLR_BIT 0
`define CPL_COMB_BIT 3
`define CPL_LAT_OT_POS 8
`define CPL_LAT_RT_POS 16
`define CPL_STAT_RED_POS 8
`endif

// [rtl/cpl_core.sv]
/*
 per-channel fault handling of a multi-channel high-side switch, with an
 AXI4-Lite register slave. assumes comparator and sensor flags arrive
 asynchronously from the power stage and are resynchronised here.
*/
`include "cpl_cfg.svh"

// What this block does
// - high drain-source voltage and trip level while turning on: off, latch
// - after trip delay with no over-temperature, use the reduced threshold
// - trip delay restarts on dynamic or over-current shutdown, input change
// - on and reduced threshold exceeded: switch off and latch at once
// - over-current latch holds until software writes one to latch clear
// - after latch clear, channel returns on at once if still requested
// - over-temperature flag switches channel off and sets its latch
// - over-temperature latch clears only when cooled and clear command given
// - dynamic temperature trip switches off, reactivates automatically later
// - reactivations counted; beyond limit, retry latch until latch clear
// - below limit, a rising request resets the reactivation count
// - error flag set while in dynamic temperature shutdown
// - reading error flag clears it; set again while fault persists
// - during auto restart the flag is clearable and set on new trip
// - supply over-voltage adds no shutdown; channel follows request
// - error flag also set during over-current shutdown
// - combine select bit 3 picks OR or AND of pin and output bit
// - output control bit zero means off, one means on
module cpl_core
	import cpl_pkg::*;
#(
	parameter int NCH = `CPL_NCH,
	parameter int TRIP_CYC = `CPL_TRIP_CYC,
	parameter int RETRY_LIMIT = `CPL_RETRY_LIMIT
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NCH-1:0] in_pin,
	input wire logic [NCH-1:0] vds_high,
	input wire logic [NCH-1:0] oc_vtrip,
	input wire logic [NCH-1:0] oc_itrip,
	input wire logic [NCH-1:0] over_temp,
	input wire logic [NCH-1:0] temp_cooled,
	input wire logic [NCH-1:0] dyn_temp,
	output logic [NCH-1:0] ch_on,
	output logic [NCH-1:0] red_thr_sel
);
	localparam int SW = 7 * NCH;
	localparam int TW = $clog2(TRIP_CYC + 1);
	localparam logic [TW-1:0] TRIP_END = TW'(TRIP_CYC);
	localparam logic [3:0] RLIM = 4'(RETRY_LIMIT);
	// true for offsets this slave answers on; status words are read-only
	function automatic logic is_mapped(input logic [7:0] a, input logic wr);
		return (a == `CPL_OUT_OFS) || (a == `CPL_HARDWARE_CONFIG_REG_OFS)
			|| (a == `CPL_CFG_OFS) || (!wr && ((a == `CPL_ERR_OFS)
			|| (a == `CPL_LAT_OFS) || (a == `CPL_STAT_OFS)));
	endfunction
	logic [SW-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
	logic [NCH-1:0] pin_f, vds_f, vtrip_f, itrip_f, ot_f, cool_f, dyn_f;
	logic [NCH-1:0] out_reg, out_prev_reg, pin_prev_reg;
	logic comb_and_reg, clr_reg;
	logic [NCH-1:0] oc_reg, ot_reg, rt_reg, pause_reg, err_reg;
	logic [TW-1:0] trip_cnt_reg [NCH];
	logic [3:0] retry_cnt_reg [NCH];
	logic [NCH-1:0] req, req_prev, rise, chg, oc_set, dyn_trip, react, kill;
	logic [NCH-1:0] rt_set, blocked;
	logic aw_got_reg, w_got_reg, aw_hs, w_hs, ar_hs, wr_go, err_rd;
	logic [7:0] wa_reg, wa;
	logic [31:0] wd_reg, wd;
	logic [3:0] ws_reg, ws;
	// pins and comparators: three stages, a change counts when 2 and 3 agree
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			flt_reg <= '0;
		end
		else
		begin
			s1_reg <= {in_pin, vds_high, oc_vtrip, oc_itrip, over_temp,
				temp_cooled, dyn_temp};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			flt_reg <= (s2_reg == s3_reg) ? s3_reg : flt_reg;
		end
	end
	assign {pin_f, vds_f, vtrip_f, itrip_f, ot_f, cool_f, dyn_f} = flt_reg;
	// request forming; change detect feeds the trip delay and retry reset
	assign req = comb_and_reg ? (pin_f & out_reg)
		: (pin_f | out_reg);
	assign req_prev = comb_and_reg ? (pin_prev_reg & out_prev_reg)
		: (pin_prev_reg | out_prev_reg);
	assign rise = req & ~req_prev;
	assign chg = (pin_f ^ pin_prev_reg) | (out_reg ^ out_prev_reg);
	// fault events of this cycle
	assign oc_set = ch_on & ((vds_f & vtrip_f & ~red_thr_sel)
		| (red_thr_sel & itrip_f));
	assign dyn_trip = dyn_f & ch_on & ~pause_reg;
	assign react = pause_reg & ~dyn_f;
	assign kill = oc_set | ot_f | dyn_trip;
	assign blocked = oc_reg | ot_reg | rt_reg | pause_reg;
	// retry latch source and reduced threshold select, per channel
	always_comb
	begin
		rt_set = '0;
		red_thr_sel = '0;
		for (int i = 0; i < NCH; i++)
		begin
			rt_set[i] = react[i] && (retry_cnt_reg[i] == RLIM);
			red_thr_sel[i] = (trip_cnt_reg[i] == TRIP_END);
		end
	end
	// switch drive plus pin and output bit history for edge detection;
	// supply over-voltage is not a shutdown source
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ch_on <= '0;
			pin_prev_reg <= '0;
			out_prev_reg <= '0;
		end
		else
		begin
			ch_on <= req & ~blocked & ~kill;
			pin_prev_reg <= pin_f;
			out_prev_reg <= out_reg;
		end
	end
	// latches and restart pause: the setting event wins over a clear
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			oc_reg <= '0;
			ot_reg <= '0;
			rt_reg <= '0;
			pause_reg <= '0;
		end
		else
		begin
			oc_reg <= (oc_reg & ~{NCH{clr_reg}}) | oc_set;
			// no clock-free path here: unpowered latching is analog's job
			ot_reg <= (ot_reg & ~({NCH{clr_reg}} & cool_f)) | ot_f;
			rt_reg <= (rt_reg & ~{NCH{clr_reg}}) | rt_set;
			// pause ends when the dynamic sensor releases
			pause_reg <= (pause_reg & dyn_f) | dyn_trip;
		end
	end
	// reactivation count, restarted by a rising request below the limit;
	// trip delay saturates, its end selects the reduced threshold
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				retry_cnt_reg[i] <= 4'h0;
				trip_cnt_reg[i] <= '0;
			end
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (clr_reg && rt_reg[i])
					retry_cnt_reg[i] <= 4'h0;
				else if (react[i] && retry_cnt_reg[i] != RLIM)
					retry_cnt_reg[i] <= retry_cnt_reg[i] + 4'h1;
				else if (rise[i] && retry_cnt_reg[i] < RLIM)
					retry_cnt_reg[i] <= 4'h0;
				if (!ch_on[i] || ot_reg[i] || kill[i] || chg[i])
					trip_cnt_reg[i] <= '0;
				else if (trip_cnt_reg[i] != TRIP_END)
					trip_cnt_reg[i] <= trip_cnt_reg[i] + TW'(1);
			end
		end
	end
	// error flags: read clears, a live over-current or dynamic temperature fault sets again and wins
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			err_reg <= '0;
		else
			err_reg <= (err_reg & ~{NCH{err_rd}})
				| pause_reg | dyn_trip
				| oc_reg | oc_set;
	end
	// write side: address and data may come in either order
	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign wa = aw_hs ? s_axi_awaddr : wa_reg;
	assign wd = w_hs ? s_axi_wdata : wd_reg;
	assign ws = w_hs ? s_axi_wstrb : ws_reg;
	assign wr_go = (aw_hs || aw_got_reg) && (w_hs || w_got_reg);
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			wa_reg <= 8'h00;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CPL_OKAY;
		end
		else
		begin
			if (aw_hs)
				wa_reg <= s_axi_awaddr;
			if (w_hs)
			begin
				wd_reg <= s_axi_wdata;
				ws_reg <= s_axi_wstrb;
			end
			aw_got_reg <= (aw_got_reg || aw_hs) && !wr_go;
			w_got_reg <= (w_got_reg || w_hs) && !wr_go;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(wa, 1'b1) ? CPL_OKAY : CPL_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	// control registers; latch clear is a one-cycle pulse, reads as zero
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_reg <= '0;
			comb_and_reg <= 1'b0;
			clr_reg <= 1'b0;
		end
		else
		begin
			clr_reg <= wr_go && ws[0] && (wa == `CPL_HARDWARE_CONFIG_REG_OFS)
				&& wd[`CPL_CLR_BIT];
			if (wr_go && ws[0] && (wa == `CPL_OUT_OFS))
				out_reg <= wd[NCH-1:0];
			if (wr_go && ws[0] && (wa == `CPL_CFG_OFS))
				comb_and_reg <= wd[`CPL_COMB_BIT];
		end
	end
	// read side: one read at a time, data registered with the response
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign err_rd = ar_hs && (s_axi_araddr == `CPL_ERR_OFS);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= CPL_OKAY;
		end
		else if (ar_hs)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(s_axi_araddr, 1'b0) ? CPL_OKAY : CPL_SLVERR;
			s_axi_rdata <= 32'h0000_0000;
			case (s_axi_araddr)
				`CPL_OUT_OFS: s_axi_rdata[NCH-1:0] <= out_reg;
				`CPL_CFG_OFS: s_axi_rdata[`CPL_COMB_BIT] <= comb_and_reg;
				`CPL_ERR_OFS: s_axi_rdata[NCH-1:0] <= err_reg;
				`CPL_LAT_OFS:
				begin
					s_axi_rdata[NCH-1:0] <= oc_reg;
					s_axi_rdata[`CPL_LAT_OT_POS +: NCH] <= ot_reg;
					s_axi_rdata[`CPL_LAT_RT_POS +: NCH] <= rt_reg;
				end
				`CPL_STAT_OFS:
				begin
					s_axi_rdata[NCH-1:0] <= ch_on;
					s_axi_rdata[`CPL_STAT_RED_POS +: NCH] <= red_thr_sel;
				end
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	// checks on channel 0; all channels share the same vector logic
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	vtrip_off_a: assert property (oc_set[0] && vds_f[0] && !red_thr_sel[0]
		|=> !ch_on[0] && oc_reg[0]) else $error("high vds trip not latched");
	red_sel_a: assert property ($rose(red_thr_sel[0])
		|-> $past(ch_on[0], 1) && !ot_reg[0]) else $error("bad reduced select");
	delay_reset_a: assert property (chg[0] || dyn_trip[0]
		|=> trip_cnt_reg[0] == '0) else $error("trip delay not restarted");
	itrip_off_a: assert property (ch_on[0] && red_thr_sel[0] && itrip_f[0]
		|=> !ch_on[0] && oc_reg[0]) else $error("reduced trip not latched");
	oc_hold_a: assert property (oc_reg[0] && !clr_reg
		|=> oc_reg[0] && !ch_on[0]) else $error("oc latch released early");
	clr_on_a: assert property (clr_reg && !oc_set[0] && !ot_f[0]
		&& !ot_reg[0] && !rt_reg[0] && !pause_reg[0] && !dyn_f[0]
		##1 req[0] && $stable(req[0]) && !kill[0] |=> ch_on[0])
		else $error("no turn-on after clear");
	ot_latch_a: assert property (ot_f[0] |=> ot_reg[0] && !ch_on[0])
		else $error("over-temperature not latched");
	ot_hold_a: assert property (ot_reg[0] && !cool_f[0] |=> ot_reg[0])
		else $error("ot latch left while hot");
	retry_hold_a: assert property (rt_reg[0] && !clr_reg
		|=> rt_reg[0] && !ch_on[0]) else $error("retry latch released early");
	err_set_a: assert property (pause_reg[0] |=> err_reg[0])
		else $error("error flag missing in pause");
	oc_trip_c: cover property (oc_set[0] ##[1:20] clr_reg);
	retry_c: cover property ($rose(rt_reg[0]));
	red_c: cover property ($rose(red_thr_sel[0]));
	err_rd_c: cover property (err_rd && err_reg[0]);
endmodule

// [rtl/cpl_pkg.sv]
/*
 types for the channel protection latch logic.
 assumes nothing beyond a SystemVerilog package scope.
*/
package cpl_pkg;
	typedef enum logic [1:0]
	{
		CPL_OKAY = 2'h0,
		CPL_SLVERR = 2'h2
	} cpl_resp_t;
endpackage
